// >>> rtl/pfd_core.sv
// flags datapath: status word, general registers, pointer, execute control
// Operation
// - carry flag bit 0 set on carry out of or borrow into top bit
// - parity flag bit 2 set when low result byte has even ones
// - aux carry bit 4 set on carry or borrow of low nibble
// - zero flag bit 6 set exactly when result is zero
// - sign flag bit 7 copies top bit of the result
// - single-step bit 8 raises trap after next instruction, trap clears it
// - maskable interrupts taken only while enable bit 9 is set
// - direction bit 10 set makes string ops decrement indexes, else increment
// - overflow bit 11 set when signed result misfits destination width
// - status word is 16 bits, six result flags, three control flags
// - four general registers work as words or as two byte halves
// - instruction pointer holds next instruction offset, advances on completion
// - flag byte loads into accumulator high byte; store writes it back
// - whole status word can be pushed onto and popped off the stack
// - separate instructions set and clear interrupt enable, others untouched
// - add with carry sums operands plus carry, updates result flags
// - subtract with borrow removes source and carry from destination
// - rotates through carry treat carry as an extra bit position
// - halt stops execution until an interrupt or reset
// - jump-if-count-zero branches on zero count, flags untouched
// - operands come from register, immediate field or memory
`timescale 1ns/100ps
module pfd_core (
    input  wire logic                CLOCK,
    input  wire logic                RST,
    input  wire logic                INSTR_VALID,
    input  wire pfd_pkg::pfd_instr_t INSTR,
    input  wire logic [15:0]         MEM_RDATA,
    input  wire logic                INT_REQ,
    input  wire logic [15:0]         INT_VECTOR,
    output logic                     INSTR_READY,
    output logic                     STACK_WR,
    output logic                     STACK_RD,
    output logic [15:0]              STACK_ADDR,
    output logic [15:0]              STACK_WDATA,
    output logic [15:0]              PROCESSOR_FLAGS_WORD,
    output logic [15:0]              IP,
    output logic                     HALTED,
    output logic                     INT_ACK,
    output logic                     STEP_TRAP
);
    typedef enum logic [2:0] {
        PFD_RUN  = 3'b001,
        PFD_POP  = 3'b010,
        PFD_HALT = 3'b100
    } pfd_state_t;

    pfd_state_t  state_q, state_d;
    logic [15:0] flags_q, flags_d;
    logic [15:0] ip_q, ip_d;
    logic [15:0] regs_q [8];
    logic [15:0] regs_d [8];
    logic        step_arm_q, step_arm_d;
    logic        swr_d, srd_d, ack_d, trap_d;
    logic [15:0] saddr_d, swdata_d;
    logic        swr_q, srd_q, ack_q, trap_q;
    logic [15:0] saddr_q, swdata_q;

    logic [15:0] opa, opb, alu_res;
    logic        c_o, a_o, v_o, p_o, z_o, s_o;
    logic        exec;
    logic        int_take;

    // byte registers 0..3 low halves, 4..7 map to high halves of 0..3
    function automatic logic [15:0] rd_op(input logic [15:0] r [8],
                                           input logic [2:0] idx,
                                           input logic w);
        if (w)
            return r[idx];
        else if (!idx[2])
            return {8'h00, r[idx[1:0]][7:0]};
        else
            return {8'h00, r[idx[1:0]][15:8]};
    endfunction

    always_comb begin
        opa = rd_op(regs_q, INSTR.dst, INSTR.word);
        unique case (INSTR.src_sel)
            pfd_pkg::PFD_SRC_REG: opb = rd_op(regs_q, INSTR.src,
                                               INSTR.word);
            pfd_pkg::PFD_SRC_IMM: opb = INSTR.imm;
            pfd_pkg::PFD_SRC_MEM: opb = MEM_RDATA;
            default:              opb = 16'h0000;
        endcase
        if (!INSTR.word)
            opb = {8'h00, opb[7:0]};
    end

    pfd_alu u_alu (
        .op       (INSTR.op),
        .word     (INSTR.word),
        .a        (opa),
        .b        (opb),
        .cin      (flags_q[pfd_pkg::CARRY_BIT]),
        .res      (alu_res),
        .c_out    (c_o),
        .aux_out  (a_o),
        .ovf_out  (v_o),
        .par_out  (p_o),
        .zero_out (z_o),
        .sign_out (s_o)
    );

    // maskable requests wait while the enable bit is clear
    assign int_take = INT_REQ && flags_q[pfd_pkg::INT_EN_BIT];
    assign exec = (state_q == PFD_RUN) && INSTR_VALID && !int_take
                  && !step_arm_q;

    always_comb begin
        state_d    = state_q;
        flags_d    = flags_q;
        ip_d       = ip_q;
        regs_d     = regs_q;
        step_arm_d = step_arm_q;
        swr_d      = 1'b0;
        srd_d      = 1'b0;
        ack_d      = 1'b0;
        trap_d     = 1'b0;
        saddr_d    = saddr_q;
        swdata_d   = swdata_q;
        unique case (state_q)
            PFD_RUN: begin
                if (step_arm_q) begin
                    trap_d     = 1'b1;
                    step_arm_d = 1'b0;
                    flags_d[pfd_pkg::STEP_BIT] = 1'b0;
                end else if (int_take) begin
                    ack_d = 1'b1;
                    ip_d  = INT_VECTOR;
                end else if (exec) begin
                    ip_d = ip_q + {12'h000, INSTR.len};
                    step_arm_d = flags_q[pfd_pkg::STEP_BIT];
                    unique case (INSTR.op)
                        pfd_pkg::PFD_OP_ADD, pfd_pkg::PFD_OP_ADC,
                        pfd_pkg::PFD_OP_SUB, pfd_pkg::PFD_OP_SUBB,
                        pfd_pkg::PFD_OP_AND, pfd_pkg::PFD_OP_OR,
                        pfd_pkg::PFD_OP_XOR: begin
                            flags_d[pfd_pkg::CARRY_BIT]  = c_o;
                            flags_d[pfd_pkg::PARITY_BIT] = p_o;
                            flags_d[pfd_pkg::AUX_BIT]    = a_o;
                            flags_d[pfd_pkg::ZERO_BIT]   = z_o;
                            flags_d[pfd_pkg::SIGN_BIT]   = s_o;
                            flags_d[pfd_pkg::OVF_BIT]    = v_o;
                        end
                        pfd_pkg::PFD_OP_ROTCL, pfd_pkg::PFD_OP_ROTCR: begin
                            flags_d[pfd_pkg::CARRY_BIT] = c_o;
                            flags_d[pfd_pkg::OVF_BIT]   = v_o;
                        end
                        pfd_pkg::PFD_OP_FL2ACC:
                            regs_d[0][15:8] = flags_q[7:0];
                        pfd_pkg::PFD_OP_ACC2FL:
                            flags_d[7:0] = (regs_q[0][15:8]
                                & pfd_pkg::FLAGS_WMASK[7:0])
                                | pfd_pkg::FLAGS_FIXED[7:0];
                        pfd_pkg::PFD_OP_PUSHW: begin
                            regs_d[pfd_pkg::REG_SP] =
                                regs_q[pfd_pkg::REG_SP] - 16'h0002;
                            saddr_d  = regs_q[pfd_pkg::REG_SP] - 16'h0002;
                            swdata_d = flags_q;
                            swr_d    = 1'b1;
                        end
                        pfd_pkg::PFD_OP_POPW: begin
                            saddr_d = regs_q[pfd_pkg::REG_SP];
                            srd_d   = 1'b1;
                            state_d = PFD_POP;
                        end
                        pfd_pkg::PFD_OP_SETIE:
                            flags_d[pfd_pkg::INT_EN_BIT] = 1'b1;
                        pfd_pkg::PFD_OP_CLRIE:
                            flags_d[pfd_pkg::INT_EN_BIT] = 1'b0;
                        pfd_pkg::PFD_OP_HALT:
                            state_d = PFD_HALT;
                        pfd_pkg::PFD_OP_JCZ:
                            if (regs_q[pfd_pkg::REG_COUNT] == 16'h0000)
                                ip_d = ip_q + {12'h000, INSTR.len}
                                       + INSTR.imm;
                        pfd_pkg::PFD_OP_STRNG: begin
                            if (flags_q[pfd_pkg::DIR_BIT]) begin
                                regs_d[pfd_pkg::REG_SRC_IDX] =
                                    regs_q[pfd_pkg::REG_SRC_IDX]
                                    - (INSTR.word ? 16'h0002 : 16'h0001);
                                regs_d[pfd_pkg::REG_DST_IDX] =
                                    regs_q[pfd_pkg::REG_DST_IDX]
                                    - (INSTR.word ? 16'h0002 : 16'h0001);
                            end else begin
                                regs_d[pfd_pkg::REG_SRC_IDX] =
                                    regs_q[pfd_pkg::REG_SRC_IDX]
                                    + (INSTR.word ? 16'h0002 : 16'h0001);
                                regs_d[pfd_pkg::REG_DST_IDX] =
                                    regs_q[pfd_pkg::REG_DST_IDX]
                                    + (INSTR.word ? 16'h0002 : 16'h0001);
                            end
                        end
                        default: ;
                    endcase
                    // result writeback into word or byte half
                    if (INSTR.op inside {pfd_pkg::PFD_OP_ADD,
                            pfd_pkg::PFD_OP_ADC, pfd_pkg::PFD_OP_SUB,
                            pfd_pkg::PFD_OP_SUBB, pfd_pkg::PFD_OP_AND,
                            pfd_pkg::PFD_OP_OR, pfd_pkg::PFD_OP_XOR,
                            pfd_pkg::PFD_OP_ROTCL, pfd_pkg::PFD_OP_ROTCR,
                            pfd_pkg::PFD_OP_MOV}) begin
                        if (INSTR.op == pfd_pkg::PFD_OP_MOV)
                            ; // mov takes opb, flags untouched
                        if (INSTR.word)
                            regs_d[INSTR.dst] =
                                (INSTR.op == pfd_pkg::PFD_OP_MOV) ? opb
                                                                   : alu_res;
                        else if (!INSTR.dst[2])
                            regs_d[INSTR.dst[1:0]][7:0] =
                                (INSTR.op == pfd_pkg::PFD_OP_MOV)
                                ? opb[7:0] : alu_res[7:0];
                        else
                            regs_d[INSTR.dst[1:0]][15:8] =
                                (INSTR.op == pfd_pkg::PFD_OP_MOV)
                                ? opb[7:0] : alu_res[7:0];
                    end
                end
            end
            PFD_POP: begin
                // stack read data is taken from MEM_RDATA in the same cycle as the strobe
                flags_d = (MEM_RDATA & pfd_pkg::FLAGS_WMASK)
                          | pfd_pkg::FLAGS_FIXED;
                regs_d[pfd_pkg::REG_SP] =
                    regs_q[pfd_pkg::REG_SP] + 16'h0002;
                state_d = PFD_RUN;
            end
            PFD_HALT: begin
                // halt is left only on a taken interrupt or on reset
                if (int_take) begin
                    ack_d   = 1'b1;
                    ip_d    = INT_VECTOR;
                    state_d = PFD_RUN;
                end
            end
        endcase
    end

    always_ff @(posedge CLOCK) begin
        if (RST) begin
            state_q    <= PFD_RUN;
            flags_q    <= pfd_pkg::FLAGS_RESET;
            ip_q       <= pfd_pkg::IP_RESET;
            regs_q     <= '{default: 16'h0000};
            step_arm_q <= 1'b0;
            swr_q      <= 1'b0;
            srd_q      <= 1'b0;
            ack_q      <= 1'b0;
            trap_q     <= 1'b0;
            saddr_q    <= pfd_pkg::SP_RESET;
            swdata_q   <= 16'h0000;
        end else begin
            state_q    <= state_d;
            flags_q    <= flags_d;
            ip_q       <= ip_d;
            regs_q     <= regs_d;
            step_arm_q <= step_arm_d;
            swr_q      <= swr_d;
            srd_q      <= srd_d;
            ack_q      <= ack_d;
            trap_q     <= trap_d;
            saddr_q    <= saddr_d;
            swdata_q   <= swdata_d;
        end
    end

    logic ready_q;
    always_ff @(posedge CLOCK) begin
        if (RST)
            ready_q <= 1'b0;
        else
            ready_q <= (state_d == PFD_RUN) && !step_arm_d;
    end

    assign INSTR_READY          = ready_q;
    assign STACK_WR             = swr_q;
    assign STACK_RD             = srd_q;
    assign STACK_ADDR           = saddr_q;
    assign STACK_WDATA          = swdata_q;
    assign PROCESSOR_FLAGS_WORD = flags_q;
    assign IP                   = ip_q;
    assign HALTED               = (state_q == PFD_HALT);
    assign INT_ACK              = ack_q;
    assign STEP_TRAP            = trap_q;
endmodule

// >>> rtl/pfd_pkg.sv
// package: status word layout, opcodes, register indices for the flags datapath
package pfd_pkg;
    localparam int CARRY_BIT     = 0;
    localparam int PARITY_BIT    = 2;
    localparam int AUX_BIT       = 4;
    localparam int ZERO_BIT      = 6;
    localparam int SIGN_BIT      = 7;
    localparam int STEP_BIT      = 8;
    localparam int INT_EN_BIT    = 9;
    localparam int DIR_BIT       = 10;
    localparam int OVF_BIT       = 11;
    // reserved bits read their fixed values from reset on
    localparam logic [15:0] FLAGS_RESET   = 16'hF002;
    localparam logic [15:0] FLAGS_FIXED   = 16'hF002;
    localparam logic [15:0] FLAGS_WMASK   = 16'h0FD5;
    localparam logic [15:0] IP_RESET      = 16'h0000;
    localparam logic [15:0] SP_RESET      = 16'h0000;
    localparam logic [2:0]  REG_COUNT     = 3'h1;
    localparam logic [2:0]  REG_SP        = 3'h4;
    localparam logic [2:0]  REG_SRC_IDX   = 3'h6;
    localparam logic [2:0]  REG_DST_IDX   = 3'h7;

    typedef enum logic [4:0] {
        PFD_OP_NOP   = 5'h00,
        PFD_OP_ADD   = 5'h01,
        PFD_OP_ADC   = 5'h02,
        PFD_OP_SUB   = 5'h03,
        PFD_OP_SUBB  = 5'h04,
        PFD_OP_AND   = 5'h05,
        PFD_OP_OR    = 5'h06,
        PFD_OP_XOR   = 5'h07,
        PFD_OP_ROTCL = 5'h08,
        PFD_OP_ROTCR = 5'h09,
        PFD_OP_FL2ACC = 5'h0A,
        PFD_OP_ACC2FL = 5'h0B,
        PFD_OP_PUSHW = 5'h0C,
        PFD_OP_POPW  = 5'h0D,
        PFD_OP_SETIE = 5'h0E,
        PFD_OP_CLRIE = 5'h0F,
        PFD_OP_HALT  = 5'h10,
        PFD_OP_JCZ   = 5'h11,
        PFD_OP_STRNG = 5'h12,
        PFD_OP_MOV   = 5'h13
    } pfd_op_t;

    // operand source selection
    typedef enum logic [1:0] {
        PFD_SRC_NONE = 2'h0,
        PFD_SRC_REG  = 2'h1,
        PFD_SRC_IMM  = 2'h2,
        PFD_SRC_MEM  = 2'h3
    } pfd_src_t;

    typedef struct packed {
        pfd_op_t     op;
        logic        word;
        logic [2:0]  dst;
        logic [2:0]  src;
        pfd_src_t    src_sel;
        logic [15:0] imm;
        logic [3:0]  len;
    } pfd_instr_t;
endpackage

// >>> rtl/pfd_alu.sv
// arithmetic and logic unit producing result and result flags
`timescale 1ns/100ps
module pfd_alu (
    input  wire pfd_pkg::pfd_op_t op,
    input  wire logic             word,
    input  wire logic [15:0]      a,
    input  wire logic [15:0]      b,
    input  wire logic             cin,
    output logic [15:0]           res,
    output logic                  c_out,
    output logic                  aux_out,
    output logic                  ovf_out,
    output logic                  par_out,
    output logic                  zero_out,
    output logic                  sign_out
);
    logic [16:0] wide;
    logic [4:0]  nib;
    logic        msb_a;
    logic        msb_b;
    logic        msb_r;
    logic        ci;
    logic        sub;

    always_comb begin
        ci  = 1'b0;
        sub = 1'b0;
        wide = 17'h00000;
        nib  = 5'h00;
        ovf_out = 1'b0;
        aux_out = 1'b0;
        c_out   = 1'b0;
        res     = 16'h0000;
        unique case (op)
            pfd_pkg::PFD_OP_ADC, pfd_pkg::PFD_OP_SUBB: ci = cin;
            default: ci = 1'b0;
        endcase
        sub = (op == pfd_pkg::PFD_OP_SUB) || (op == pfd_pkg::PFD_OP_SUBB);
        msb_a = word ? a[15] : a[7];
        msb_b = word ? b[15] : b[7];
        unique case (op)
            pfd_pkg::PFD_OP_ADD, pfd_pkg::PFD_OP_ADC: begin
                wide = word ? {1'b0, a} + {1'b0, b} + {16'h0000, ci}
                            : {9'h000, a[7:0]} + {9'h000, b[7:0]}
                              + {16'h0000, ci};
                nib  = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, ci};
            end
            pfd_pkg::PFD_OP_SUB, pfd_pkg::PFD_OP_SUBB: begin
                wide = word ? {1'b0, a} - {1'b0, b} - {16'h0000, ci}
                            : {9'h000, a[7:0]} - {9'h000, b[7:0]}
                              - {16'h0000, ci};
                nib  = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, ci};
            end
            pfd_pkg::PFD_OP_AND: wide = {1'b0, a & b};
            pfd_pkg::PFD_OP_OR:  wide = {1'b0, a | b};
            pfd_pkg::PFD_OP_XOR: wide = {1'b0, a ^ b};
            // carry acts as an extra bit of the rotation
            pfd_pkg::PFD_OP_ROTCL: wide = word ? {a, cin}
                : {8'h00, a[7:0], cin};
            pfd_pkg::PFD_OP_ROTCR: wide = word ? {a[0], cin, a[15:1]}
                : {a[0], 8'h00, cin, a[7:1]};
            default: wide = {1'b0, a};
        endcase
        res   = word ? wide[15:0] : {8'h00, wide[7:0]};
        c_out = word ? wide[16] : (op == pfd_pkg::PFD_OP_ROTCR ? wide[16]
                                                            : wide[8]);
        aux_out = nib[4];
        msb_r = word ? res[15] : res[7];
        if (sub)
            ovf_out = (msb_a != msb_b) && (msb_r != msb_a);
        else if (op == pfd_pkg::PFD_OP_ADD || op == pfd_pkg::PFD_OP_ADC)
            ovf_out = (msb_a == msb_b) && (msb_r != msb_a);
        else if (op == pfd_pkg::PFD_OP_ROTCL)
            ovf_out = msb_r ^ c_out;
        else if (op == pfd_pkg::PFD_OP_ROTCR)
            ovf_out = msb_r ^ (word ? res[14] : res[6]);
    end

    assign par_out  = ~^res[7:0];
    assign zero_out = (res == 16'h0000);
    assign sign_out = word ? res[15] : res[7];
endmodule

// >>> tb/pfd_monitor.sv
// checker: port-level properties of the flags datapath core
`timescale 1ns/100ps
module pfd_monitor (
    input wire logic        CLOCK,
    input wire logic        RST,
    input wire logic        INT_REQ,
    input wire logic [15:0] INT_VECTOR,
    input wire logic [15:0] MEM_RDATA,
    input wire logic        STACK_WR,
    input wire logic        STACK_RD,
    input wire logic [15:0] STACK_WDATA,
    input wire logic [15:0] PROCESSOR_FLAGS_WORD,
    input wire logic [15:0] IP,
    input wire logic        HALTED,
    input wire logic        INT_ACK,
    input wire logic        STEP_TRAP
);
    localparam logic [15:0] WM = pfd_pkg::FLAGS_WMASK;
    default clocking dc @(posedge CLOCK); endclocking
    default disable iff (RST);

    a_fixed_bit_set: assert property (PROCESSOR_FLAGS_WORD[1])
        else $error("fixed status bit low");
    a_reset_state: assert property ($past(RST) |->
        PROCESSOR_FLAGS_WORD == pfd_pkg::FLAGS_RESET && IP == 16'h0000
        && !HALTED)
        else $error("state after reset wrong");
    a_push_data: assert property (STACK_WR |->
        STACK_WDATA == PROCESSOR_FLAGS_WORD ##1 !STACK_WR)
        else $error("pushed word differs from flags");
    a_pop_load: assert property (STACK_RD |=>
        (PROCESSOR_FLAGS_WORD & WM) == ($past(MEM_RDATA) & WM))
        else $error("popped word not loaded");
    a_trap_clears: assert property (STEP_TRAP |=>
        !PROCESSOR_FLAGS_WORD[pfd_pkg::STEP_BIT] && !STEP_TRAP)
        else $error("step flag kept after trap");
    a_ack_gated: assert property (INT_ACK |->
        $past(PROCESSOR_FLAGS_WORD[pfd_pkg::INT_EN_BIT])
        && IP == $past(INT_VECTOR))
        else $error("interrupt taken wrongly");
    a_halt_holds: assert property (HALTED && !INT_REQ |=> HALTED)
        else $error("halt left without interrupt");
    a_halt_ip_still: assert property (HALTED |=> $stable(IP) || INT_ACK)
        else $error("pointer moved while halted");

    c_pop: cover property (STACK_RD);
    c_trap: cover property (STEP_TRAP);
    c_wake: cover property (HALTED ##1 INT_ACK);
endmodule

// >>> tb/processor_flags_datapath_test.sv
// testbench: instruction sequences against the flags datapath core
`timescale 1ns/100ps
module processor_flags_datapath_test;
    logic                CLOCK, RST, INSTR_VALID, INT_REQ;
    pfd_pkg::pfd_instr_t INSTR;
    logic [15:0]         MEM_RDATA, INT_VECTOR, STACK_ADDR, STACK_WDATA;
    logic [15:0]         PROCESSOR_FLAGS_WORD, IP;
    logic                INSTR_READY, STACK_WR, STACK_RD;
    logic                HALTED, INT_ACK, STEP_TRAP;
    int                  fail_count = 0;
    int                  checks = 0;

    pfd_core pfd_core_i (.CLOCK(CLOCK), .RST(RST), .INSTR_VALID(INSTR_VALID),
        .INSTR(INSTR), .MEM_RDATA(MEM_RDATA), .INT_REQ(INT_REQ),
        .INT_VECTOR(INT_VECTOR), .INSTR_READY(INSTR_READY),
        .STACK_WR(STACK_WR), .STACK_RD(STACK_RD), .STACK_ADDR(STACK_ADDR),
        .STACK_WDATA(STACK_WDATA), .IP(IP), .HALTED(HALTED),
        .PROCESSOR_FLAGS_WORD(PROCESSOR_FLAGS_WORD), .INT_ACK(INT_ACK),
        .STEP_TRAP(STEP_TRAP));

    task automatic final_report;
        $display("checks %0d fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic chk(string nm, logic [15:0] seen, logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic fl(logic [15:0] exp);
        chk("flags", PROCESSOR_FLAGS_WORD & pfd_pkg::FLAGS_WMASK, exp);
    endtask

    // waits for ready under a bound, then issues one instruction
    task automatic run(pfd_pkg::pfd_op_t op, logic w = 1'b1,
                       logic [15:0] imm = 16'h0000, logic [2:0] d = 3'h0,
                       pfd_pkg::pfd_src_t s = pfd_pkg::PFD_SRC_IMM);
        int n;
        n = 0;
        @(negedge CLOCK);
        while (INSTR_READY !== 1'b1 && n < 20) begin
            n++;
            @(negedge CLOCK);
        end
        INSTR = '{op, w, d, 3'h0, s, imm, 4'h2};
        INSTR_VALID = 1'b1;
        @(negedge CLOCK);
        INSTR_VALID = 1'b0;
    endtask

    // pulses stand one cycle, so each negedge is looked at
    task automatic wait_pulse(bit ack);
        int n;
        n = 0;
        while ((ack ? INT_ACK : STEP_TRAP) !== 1'b1 && n < 8) begin
            n++;
            @(negedge CLOCK);
        end
        chk(ack ? "int_ack" : "step_trap", 16'(ack ? INT_ACK : STEP_TRAP),
            16'h0001);
    endtask

    initial begin
        CLOCK = 1'b0;
        forever #20 CLOCK = ~CLOCK;
    end

    initial begin
        repeat (3000) @(posedge CLOCK);
        fail_count++;
        final_report;
    end

    initial begin
        RST = 1'b1;
        INSTR_VALID = 1'b0;
        INSTR = '0;
        MEM_RDATA = 16'h0000;
        INT_REQ = 1'b0;
        INT_VECTOR = 16'h0040;
        repeat (5) @(negedge CLOCK);
        RST = 1'b0;
        chk("flags", PROCESSOR_FLAGS_WORD, pfd_pkg::FLAGS_RESET);
        run(pfd_pkg::PFD_OP_MOV, 1'b1, 16'hFFFF);
        chk("ip", IP, 16'h0002);
        run(pfd_pkg::PFD_OP_ADD, 1'b1, 16'h0001);
        fl(16'h0055);
        run(pfd_pkg::PFD_OP_ADC, 1'b1, 16'h0000, 3'h0, pfd_pkg::PFD_SRC_MEM);
        fl(16'h0000);
        run(pfd_pkg::PFD_OP_SUBB, 1'b1, 16'h0002);
        fl(16'h0095);
        run(pfd_pkg::PFD_OP_MOV, 1'b0, 16'h007F);
        run(pfd_pkg::PFD_OP_ADD, 1'b0, 16'h0001);
        fl(16'h0890);
        run(pfd_pkg::PFD_OP_ROTCL, 1'b0);
        chk("carry", 16'(PROCESSOR_FLAGS_WORD[0]), 16'h0001);
        run(pfd_pkg::PFD_OP_ROTCR, 1'b0);
        chk("carry", 16'(PROCESSOR_FLAGS_WORD[0]), 16'h0000);
        run(pfd_pkg::PFD_OP_ADD, 1'b0);
        fl(16'h0080);
        run(pfd_pkg::PFD_OP_MOV, 1'b1, 16'hD500);
        run(pfd_pkg::PFD_OP_ACC2FL);
        fl(16'h00D5);
        // byte add leaves the high half alone, so the load sees the flags saved by FL2ACC
        run(pfd_pkg::PFD_OP_ADD, 1'b0);
        run(pfd_pkg::PFD_OP_FL2ACC);
        run(pfd_pkg::PFD_OP_ADD, 1'b0, 16'h0001);
        run(pfd_pkg::PFD_OP_ACC2FL);
        fl(16'h0044);
        run(pfd_pkg::PFD_OP_PUSHW);
        chk("push_strobe", 16'(STACK_WR), 16'h0001);
        chk("push_addr", STACK_ADDR, 16'hFFFE);
        chk("push_data", STACK_WDATA, pfd_pkg::FLAGS_FIXED | 16'h0044);
        MEM_RDATA = 16'h01FF;
        run(pfd_pkg::PFD_OP_POPW);
        chk("pop_strobe", 16'(STACK_RD), 16'h0001);
        chk("pop_addr", STACK_ADDR, 16'hFFFE);
        @(negedge CLOCK);
        fl(16'h01D5);
        chk("fixed", PROCESSOR_FLAGS_WORD & ~pfd_pkg::FLAGS_WMASK,
            pfd_pkg::FLAGS_FIXED);
        run(pfd_pkg::PFD_OP_NOP);
        wait_pulse(1'b0);
        @(negedge CLOCK);
        fl(16'h00D5);
        run(pfd_pkg::PFD_OP_SETIE);
        fl(16'h02D5);
        run(pfd_pkg::PFD_OP_HALT);
        INSTR = '{pfd_pkg::PFD_OP_NOP, 1'b1, 3'h0, 3'h0,
                  pfd_pkg::PFD_SRC_IMM, 16'h0000, 4'h2};
        INSTR_VALID = 1'b1;
        repeat (3) @(negedge CLOCK);
        chk("halted", 16'(HALTED), 16'h0001);
        INSTR_VALID = 1'b0;
        INT_REQ = 1'b1;
        wait_pulse(1'b1);
        INT_REQ = 1'b0;
        chk("ip", IP, 16'h0040);
        chk("halted", 16'(HALTED), 16'h0000);
        run(pfd_pkg::PFD_OP_CLRIE);
        fl(16'h00D5);
        INT_REQ = 1'b1;
        // a masked request must not steal the instruction
        run(pfd_pkg::PFD_OP_NOP);
        chk("ip", IP, 16'h0044);
        INT_REQ = 1'b0;
        run(pfd_pkg::PFD_OP_JCZ, 1'b1, 16'h0010);
        chk("ip", IP, 16'h0056);
        fl(16'h00D5);
        run(pfd_pkg::PFD_OP_MOV, 1'b1, 16'h0005, pfd_pkg::REG_COUNT);
        run(pfd_pkg::PFD_OP_JCZ, 1'b1, 16'h0010);
        chk("ip", IP, 16'h005A);
        final_report;
    end
endmodule

bind pfd_core pfd_monitor pfd_monitor_i (.CLOCK(CLOCK), .RST(RST),
    .INT_REQ(INT_REQ), .INT_VECTOR(INT_VECTOR), .MEM_RDATA(MEM_RDATA),
    .STACK_WR(STACK_WR), .STACK_RD(STACK_RD), .STACK_WDATA(STACK_WDATA),
    .PROCESSOR_FLAGS_WORD(PROCESSOR_FLAGS_WORD), .IP(IP), .HALTED(HALTED),
    .INT_ACK(INT_ACK), .STEP_TRAP(STEP_TRAP));
